// [aacg_core.sv]
// digital core of the eight-channel converter: apb registers, serial link, averager, gpio
//
// Behaviour
// - results are unsigned straight binary, 12 bits, step is supply over 4096.
// - codes run from 000h at bottom through 800h mid to FFFh at top.
// - writing the calibration bit starts offset calibration; hardware clears it when done.
// - strap is sampled once after reset; address kept until reset or programmed.
// - strap code selects one of eight addresses 10h to 17h.
// - one 3-bit oversample field serves all channels; averaged result is 16 bits.
// - host triggers only the first conversion; device makes the remaining ones.
// - an averaging read holds serial clock low until averaging completes.
// - statistics enable plus start bit averages without stretching; done flag, result registers.
// - autonomous mode averages each channel in the sequence mask in turn.
// - window comparator uses the top 12 bits of the 16-bit result.
// - with checking on, every sent byte gets a check byte and received ones after the address byte need one.
// - check byte uses polynomial x^8 + x^2 + x + 1.
// - byte checking is active only while the checksum enable bit is set.
// - a mismatching check byte discards the data and sets the check-error flag.
// - while check-error is set all writes except to the status register are refused; writing 1 clears it.
// - with notify set, a check error asserts the alert output.
// - append select 10b replaces the low nibble of each result returned on the serial link with the check-error and alert flags and two zero bits.
// - in autonomous mode, halt setting stops new conversions after a check error.
// - channel mode comes from digital-select, direction and drive-type bits.
// - output-level register drives each digital output channel.
// - input-level register reads the level of every digital input channel.
`timescale 1ns/100ps
module aacg_core
	import aacg_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// serial link, open drain
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// address strap decoder
	input wire logic [2:0] addr_strap_i,
	// converter macro
	output logic adc_start_o,
	output logic [2:0] adc_chan_o,
	input wire logic adc_done_i,
	input wire logic [11:0] adc_code_i,
	output logic cal_start_o,
	input wire logic cal_done_i,
	// channel pins and alert
	input wire logic [7:0] gpio_i,
	output logic [7:0] gpio_o,
	output logic [7:0] gpio_oe_o,
	output logic alert_o
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] crc8(input logic [7:0] b);
		logic [7:0] c;
		c = CRC_INIT ^ b;
		for (int i = 0; i < 8; i++)
		begin
			c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction : crc8

	function automatic logic [2:0] next_chan(input logic [7:0] m, input logic [2:0] c);
		logic [2:0] r;
		logic [2:0] k;
		logic hit;
		r = c;
		hit = 1'b0;
		for (int i = 1; i <= 8; i++)
		begin
			k = c + 3'(i);
			if (!hit && m[k])
			begin
				r = k;
				hit = 1'b1;
			end
		end
		return r;
	endfunction : next_chan

	function automatic logic reg_hit(input logic [7:0] idx);
		return (idx <= REG_TLO_H) || (idx >= REG_RES_FIRST && idx <= REG_RES_LAST);
	endfunction : reg_hit

	function automatic logic [7:0] reg_read(input aacg_state_t st, input logic [7:0] idx);
		logic [15:0] r;
		r = st.res[idx[3:1]];
		case (idx)
			REG_GENERAL: return st.gen;
			REG_STATUS: return {4'h0, st.cv != CV_IDLE, st.st_alert, st.st_done, st.st_crc};
			REG_AVG: return {5'h00, st.oversample_ratio_field};
			REG_CHAN: return {3'h0, st.auto_en, 1'b0, st.man_ch};
			REG_SEQ: return st.seq;
			REG_PIN: return st.pin;
			REG_DIR: return st.dir;
			REG_DRIVE: return st.drv;
			REG_OUT: return st.out;
			REG_IN: return st.in_lvl;
			REG_ADDR: return {1'b0, st.i2c_addr};
			REG_THI_L: return st.thr_hi[7:0];
			REG_THI_H: return {4'h0, st.thr_hi[11:8]};
			REG_TLO_L: return st.thr_lo[7:0];
			REG_TLO_H: return {4'h0, st.thr_lo[11:8]};
			default: return reg_hit(idx) ? (idx[0] ? r[15:8] : r[7:0]) : 8'h00;
		endcase
	endfunction : reg_read

	// result word sent on a read, with status flags in place of the low nibble when append select is 10b
	function automatic logic [15:0] read_word(input aacg_state_t st);
		logic [15:0] r;
		r = st.res[st.man_ch];
		if (st.gen[GEN_APP_LSB+1:GEN_APP_LSB] == APPEND_SELECT_SEL)
		begin
			r = {r[15:4], st.st_crc, st.st_alert, 2'h0};
		end
		return r;
	endfunction : read_word

	function automatic logic [7:0] tx_byte(input logic [15:0] w, input logic [1:0] i);
		case (i)
			2'h0: return w[15:8];
			2'h1: return crc8(w[15:8]);
			2'h2: return w[7:0];
			default: return crc8(w[7:0]);
		endcase
	endfunction : tx_byte

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	aacg_state_t s;
	aacg_state_t next_s;

	always_comb
	begin
		logic scl_rise;
		logic scl_fall;
		logic start_c;
		logic stop_c;
		logic crc_en;
		logic rx_ok;
		logic [7:0] rx_byte;
		logic wr_en;
		logic [7:0] wr_idx;
		logic [7:0] wr_dat;
		logic set_crc;
		logic set_done;
		logic set_alert;
		logic start;
		logic [18:0] sum_nx;
		logic [7:0] cnt_nx;
		logic [22:0] scaled;
		logic [15:0] w;
		logic [1:0] ti;
		logic [7:0] b;
		logic [7:0] dout;
		logic [7:0] aidx;

		next_s = s;
		rx_ok = 1'b0;
		rx_byte = 8'h00;
		wr_en = 1'b0;
		wr_idx = 8'h00;
		wr_dat = 8'h00;
		set_crc = 1'b0;
		set_done = 1'b0;
		set_alert = 1'b0;
		start = 1'b0;
		sum_nx = s.sum + 19'(adc_code_i);
		cnt_nx = s.cnt + 8'h01;
		scaled = {sum_nx, 4'h0} >> s.oversample_ratio_field;
		w = read_word(s);
		ti = 2'h0;
		b = 8'h00;
		crc_en = s.gen[GEN_CRC_EN];
		aidx = {2'h0, paddr_i[7:2]};
		next_s.adc_start = 1'b0;
		next_s.cal_start = 1'b0;

		// synchronisers
		next_s.scl_m = scl_i;
		next_s.scl_s = s.scl_m;
		next_s.scl_d = s.scl_s;
		next_s.sda_m = sda_i;
		next_s.sda_s = s.sda_m;
		next_s.sda_d = s.sda_s;
		next_s.gpio_m = gpio_i;
		next_s.gpio_s = s.gpio_m;
		next_s.strap_m = addr_strap_i;
		next_s.strap_s = s.strap_m;
		scl_rise = s.scl_s & ~s.scl_d;
		scl_fall = ~s.scl_s & s.scl_d;
		start_c = s.scl_s & s.scl_d & s.sda_d & ~s.sda_s;
		stop_c = s.scl_s & s.scl_d & ~s.sda_d & s.sda_s;

		// strap is caught once, a few cycles after reset release so the synchroniser has settled
		if (!s.strap_done)
		begin
			if (s.strap_cnt == STRAP_SETTLE)
			begin
				next_s.i2c_addr = ADDR_BASE | {4'h0, s.strap_s};
				next_s.strap_done = 1'b1;
			end
			else
			begin
				next_s.strap_cnt = s.strap_cnt + 2'h1;
			end
		end

		// ----------------------------------------------------------------
		// serial link
		// ----------------------------------------------------------------
		case (s.ist)
			I_IDLE:
			begin
				next_s.ist = I_IDLE;
			end
			I_ADDR, I_RX:
			begin
				if (scl_rise)
				begin
					next_s.sh = {s.sh[6:0], s.sda_s};
					next_s.bitn = s.bitn + 4'h1;
				end
				if (scl_fall && s.bitn == 4'h8)
				begin
					next_s.bitn = 4'h0;
					if (s.ist == I_ADDR)
					begin
						if (s.sh[7:1] == s.i2c_addr)
						begin
							next_s.rw = s.sh[0];
							next_s.sda_oe = 1'b1;
							next_s.ist = I_ACK;
						end
						else
						begin
							next_s.ist = I_IDLE;
						end
					end
					else
					begin
						next_s.sda_oe = 1'b1;
						next_s.ist = I_ACK;
						if (s.expect_crc)
						begin
							next_s.expect_crc = 1'b0;
							if (s.sh == crc8(s.pend))
							begin
								rx_ok = 1'b1;
								rx_byte = s.pend;
							end
							else
							begin
								set_crc = 1'b1;
							end
						end
						else if (crc_en)
						begin
							next_s.pend = s.sh;
							next_s.expect_crc = 1'b1;
						end
						else
						begin
							rx_ok = 1'b1;
							rx_byte = s.sh;
						end
					end
				end
			end
			I_ACK:
			begin
				if (scl_fall)
				begin
					next_s.sda_oe = 1'b0;
					if (!s.rw)
					begin
						next_s.ist = I_RX;
					end
					else
					begin
						next_s.scl_oe = 1'b1;
						next_s.rd_req = ~s.auto_en;
						next_s.ist = I_STR;
					end
				end
			end
			I_STR:
			begin
				if (!s.rd_req && (s.cv == CV_IDLE || s.auto_en))
				begin
					next_s.txw = w;
					next_s.txi = 2'h0;
					next_s.sh = w[15:8];
					next_s.sda_oe = ~w[15];
					next_s.bitn = 4'h0;
					next_s.scl_oe = 1'b0;
					next_s.ist = I_TX;
				end
			end
			I_TX:
			begin
				if (scl_fall)
				begin
					if (s.bitn == 4'h7)
					begin
						next_s.sda_oe = 1'b0;
						next_s.ist = I_MACK;
					end
					else
					begin
						next_s.sh = {s.sh[6:0], 1'b0};
						next_s.sda_oe = ~s.sh[6];
						next_s.bitn = s.bitn + 4'h1;
					end
				end
			end
			I_MACK:
			begin
				if (scl_rise && s.sda_s)
				begin
					next_s.ist = I_IDLE;
				end
				else if (scl_fall)
				begin
					ti = s.txi + (crc_en ? 2'h1 : 2'h2);
					b = tx_byte(s.txw, ti);
					next_s.txi = ti;
					next_s.sh = b;
					next_s.sda_oe = ~b[7];
					next_s.bitn = 4'h0;
					next_s.ist = I_TX;
				end
			end
			default:
			begin
				next_s.ist = I_IDLE;
			end
		endcase
		if (start_c)
		begin
			next_s.ist = I_ADDR;
			next_s.bitn = 4'h0;
			next_s.sda_oe = 1'b0;
			next_s.ptr_ok = 1'b0;
			next_s.expect_crc = 1'b0;
		end
		else if (stop_c)
		begin
			next_s.ist = I_IDLE;
			next_s.sda_oe = 1'b0;
			next_s.scl_oe = 1'b0;
		end
		if (rx_ok)
		begin
			if (!s.ptr_ok)
			begin
				next_s.ptr = rx_byte;
				next_s.ptr_ok = 1'b1;
			end
			else
			begin
				wr_en = 1'b1;
				wr_idx = s.ptr;
				wr_dat = rx_byte;
				next_s.ptr = s.ptr + 8'h01;
			end
		end

		// ----------------------------------------------------------------
		// apb slave: read data captured in setup, answered and writes applied in the access cycle
		// ----------------------------------------------------------------
		next_s.pready = psel_i & ~penable_i;
		next_s.pslverr = 1'b0;
		next_s.prdata = 32'h0000_0000;
		if (psel_i && !penable_i)
		begin
			next_s.pslverr = (paddr_i[1:0] != 2'h0) || !reg_hit(aidx);
			if (!pwrite_i && !next_s.pslverr)
			begin
				next_s.prdata = {24'h00_0000, reg_read(s, aidx)};
			end
		end
		// the bus wins over a serial write landing in the same cycle
		if (psel_i && penable_i && s.pready && pwrite_i && !s.pslverr)
		begin
			wr_en = 1'b1;
			wr_idx = aidx;
			wr_dat = pwdata_i[7:0];
		end

		// ----------------------------------------------------------------
		// conversion and averaging engine
		// ----------------------------------------------------------------
		case (s.cv)
			CV_IDLE:
			begin
				if (s.gen[GEN_CAL])
				begin
					next_s.cal_start = 1'b1;
					next_s.cv = CV_CAL;
				end
				else if (s.rd_req)
				begin
					next_s.rd_req = 1'b0;
					next_s.ch = s.man_ch;
					start = 1'b1;
				end
				else if (s.gen[GEN_CONVERSION_START_BIT])
				begin
					next_s.gen[GEN_CONVERSION_START_BIT] = 1'b0;
					next_s.ch = s.man_ch;
					start = 1'b1;
				end
				else if (s.auto_en && s.seq != 8'h00 && !(s.gen[GEN_HALT] && s.st_crc))
				begin
					next_s.ch = s.seq[s.ch] ? s.ch : next_chan(s.seq, s.ch);
					start = 1'b1;
				end
				if (start)
				begin
					next_s.adc_start = 1'b1;
					next_s.cnt = 8'h00;
					next_s.sum = 19'h0_0000;
					next_s.cv = CV_CONV;
				end
			end
			CV_CAL:
			begin
				if (cal_done_i)
				begin
					next_s.gen[GEN_CAL] = 1'b0;
					next_s.cv = CV_IDLE;
				end
			end
			CV_CONV:
			begin
				if (adc_done_i)
				begin
					if (cnt_nx == (8'h01 << s.oversample_ratio_field))
					begin
						next_s.res[s.ch] = scaled[15:0];
						set_done = s.gen[GEN_STATS];
						set_alert = (scaled[15:4] > s.thr_hi) || (scaled[15:4] < s.thr_lo);
						next_s.cv = CV_IDLE;
						if (s.auto_en)
						begin
							next_s.ch = next_chan(s.seq, s.ch);
						end
					end
					else
					begin
						next_s.sum = sum_nx;
						next_s.cnt = cnt_nx;
						next_s.adc_start = 1'b1;
					end
				end
			end
			default:
			begin
				next_s.cv = CV_IDLE;
			end
		endcase

		// ----------------------------------------------------------------
		// register writes, then hardware flag sets so a set beats a clear
		// ----------------------------------------------------------------
		if (wr_en && reg_hit(wr_idx) && (!s.st_crc || wr_idx == REG_STATUS))
		begin
			case (wr_idx)
				REG_GENERAL: next_s.gen = wr_dat;
				REG_STATUS:
				begin
					next_s.st_crc = s.st_crc & ~wr_dat[STAT_CRC];
					next_s.st_done = s.st_done & ~wr_dat[STAT_DONE];
					next_s.st_alert = s.st_alert & ~wr_dat[STAT_ALERT];
				end
				REG_AVG: next_s.oversample_ratio_field = wr_dat[2:0];
				REG_CHAN:
				begin
					next_s.man_ch = wr_dat[2:0];
					next_s.auto_en = wr_dat[CHAN_AUTO];
				end
				REG_SEQ: next_s.seq = wr_dat;
				REG_PIN: next_s.pin = wr_dat;
				REG_DIR: next_s.dir = wr_dat;
				REG_DRIVE: next_s.drv = wr_dat;
				REG_OUT: next_s.out = wr_dat;
				REG_ADDR: next_s.i2c_addr = wr_dat[6:0];
				REG_THI_L: next_s.thr_hi[7:0] = wr_dat;
				REG_THI_H: next_s.thr_hi[11:8] = wr_dat[3:0];
				REG_TLO_L: next_s.thr_lo[7:0] = wr_dat;
				REG_TLO_H: next_s.thr_lo[11:8] = wr_dat[3:0];
				default: next_s.ptr_ok = next_s.ptr_ok;
			endcase
		end
		next_s.st_crc = next_s.st_crc | set_crc;
		next_s.st_done = next_s.st_done | set_done;
		next_s.st_alert = next_s.st_alert | set_alert;

		// ----------------------------------------------------------------
		// channel pins and alert
		// ----------------------------------------------------------------
		dout = next_s.pin & next_s.dir;
		next_s.gpio_o = next_s.out & dout;
		next_s.gpio_oe = dout & (next_s.drv | ~next_s.out);
		next_s.in_lvl = s.gpio_s & s.pin & ~s.dir;
		next_s.alert = next_s.st_alert | (next_s.st_crc & next_s.gen[GEN_NOTIFY]);
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s <= '0;
			s.cv <= CV_IDLE;
			s.ist <= I_IDLE;
			s.thr_hi <= RST_THR_HI;
			s.i2c_addr <= ADDR_BASE;
		end
		else
		begin
			s <= next_s;
		end
	end

	// open-drain lines only ever pull low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_o = s.scl_oe;
	assign sda_oe_o = s.sda_oe;
	assign prdata_o = s.prdata;
	assign pready_o = s.pready;
	assign pslverr_o = s.pslverr;
	assign adc_start_o = s.adc_start;
	assign adc_chan_o = s.ch;
	assign cal_start_o = s.cal_start;
	assign gpio_o = s.gpio_o;
	assign gpio_oe_o = s.gpio_oe;
	assign alert_o = s.alert;

endmodule : aacg_core

// [aacg_pkg.sv]
// constants, state types and register map of the converter digital core
package aacg_pkg;

	// ----------------------------------------------------------------
	// register indices (byte index on the serial bus, word index on apb)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_GENERAL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h01;
	localparam logic [7:0] REG_AVG = 8'h02;
	localparam logic [7:0] REG_CHAN = 8'h03;
	localparam logic [7:0] REG_SEQ = 8'h04;
	localparam logic [7:0] REG_PIN = 8'h05;
	localparam logic [7:0] REG_DIR = 8'h06;
	localparam logic [7:0] REG_DRIVE = 8'h07;
	localparam logic [7:0] REG_OUT = 8'h08;
	localparam logic [7:0] REG_IN = 8'h09;
	localparam logic [7:0] REG_ADDR = 8'h0A;
	localparam logic [7:0] REG_THI_L = 8'h0B;
	localparam logic [7:0] REG_THI_H = 8'h0C;
	localparam logic [7:0] REG_TLO_L = 8'h0D;
	localparam logic [7:0] REG_TLO_H = 8'h0E;
	localparam logic [7:0] REG_RES_FIRST = 8'h10;
	localparam logic [7:0] REG_RES_LAST = 8'h1F;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int GEN_CAL = 0;
	localparam int GEN_CRC_EN = 1;
	localparam int GEN_STATS = 2;
	localparam int GEN_CONVERSION_START_BIT = 3;
	localparam int GEN_APP_LSB = 4;
	localparam int GEN_NOTIFY = 6;
	localparam int GEN_HALT = 7;
	localparam int STAT_CRC = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_ALERT = 2;
	localparam int STAT_BUSY = 3;
	localparam int CHAN_AUTO = 4;

	// ----------------------------------------------------------------
	// values
	// ----------------------------------------------------------------
	localparam logic [1:0] APPEND_SELECT_SEL = 2'h2;
	localparam logic [6:0] ADDR_BASE = 7'h10;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [11:0] RST_THR_HI = 12'hFFF;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// ----------------------------------------------------------------
	// state types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {CV_IDLE = 3'h1, CV_CAL = 3'h2, CV_CONV = 3'h4} aacg_conv_t;
	typedef enum logic [6:0] {I_IDLE = 7'h01, I_ADDR = 7'h02, I_ACK = 7'h04, I_RX = 7'h08,
		I_TX = 7'h10, I_MACK = 7'h20, I_STR = 7'h40} aacg_i2c_t;

	typedef struct packed {
		aacg_conv_t cv;
		aacg_i2c_t ist;
		logic [7:0] gen;
		logic st_crc;
		logic st_done;
		logic st_alert;
		logic [2:0] oversample_ratio_field;
		logic [2:0] man_ch;
		logic auto_en;
		logic [7:0] seq;
		logic [7:0] pin;
		logic [7:0] dir;
		logic [7:0] drv;
		logic [7:0] out;
		logic [7:0] in_lvl;
		logic [6:0] i2c_addr;
		logic [11:0] thr_hi;
		logic [11:0] thr_lo;
		logic [7:0][15:0] res;
		logic [2:0] strap_m;
		logic [2:0] strap_s;
		logic [1:0] strap_cnt;
		logic strap_done;
		logic scl_m;
		logic scl_s;
		logic scl_d;
		logic sda_m;
		logic sda_s;
		logic sda_d;
		logic [7:0] gpio_m;
		logic [7:0] gpio_s;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [2:0] ch;
		logic [7:0] cnt;
		logic [18:0] sum;
		logic adc_start;
		logic cal_start;
		logic rd_req;
		logic [7:0] sh;
		logic [7:0] pend;
		logic [7:0] ptr;
		logic [3:0] bitn;
		logic rw;
		logic ptr_ok;
		logic expect_crc;
		logic [15:0] txw;
		logic [1:0] txi;
		logic scl_oe;
		logic sda_oe;
		logic [7:0] gpio_o;
		logic [7:0] gpio_oe;
		logic alert;
	} aacg_state_t;

endpackage : aacg_pkg

// [aacg_core_chk.sv]
// concurrent checks on the converter core ports
`timescale 1ns/100ps
module aacg_core_chk
	import aacg_pkg::*;
(
	// clock, reset and apb
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// serial clock and converter
	input wire logic scl_oe_o,
	input wire logic adc_start_o,
	input wire logic [2:0] adc_chan_o,
	input wire logic adc_done_i,
	input wire logic cal_start_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!resetn_i);
	wire gen_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == {REG_GENERAL[5:0], 2'h0};
	// high from a start pulse until the matching done pulse
	logic conv_q;
	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			conv_q <= 1'b0;
		else if (adc_start_o || adc_done_i)
			conv_q <= adc_start_o;
	end
	// ----
	// properties
	// ----
	property p_answer;
		psel_i && !penable_i |=> pready_o;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer after setup");
	property p_err;
		pslverr_o |-> pready_o && prdata_o == 32'h0;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_idle;
		!pready_o |-> prdata_o == 32'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("read data outside access");
	property p_cal;
		gen_wr && pwdata_i[GEN_CAL] |-> ##[1:3] cal_start_o;
	endproperty
	a_cal: assert property (p_cal) else $error("calibration not started");
	property p_conv;
		gen_wr && pwdata_i[GEN_CONVERSION_START_BIT] |-> ##[1:3] adc_start_o;
	endproperty
	a_conv: assert property (p_conv) else $error("conversion not started");
	property p_one_conv;
		conv_q && !adc_done_i |-> !adc_start_o;
	endproperty
	a_one_conv: assert property (p_one_conv) else $error("start before done");
	property p_chan_hold;
		conv_q |-> $stable(adc_chan_o);
	endproperty
	a_chan_hold: assert property (p_chan_hold) else $error("channel moved mid conversion");
	property p_stretch;
		scl_oe_o && (adc_start_o || conv_q) |=> scl_oe_o;
	endproperty
	a_stretch: assert property (p_stretch) else $error("clock released mid average");
	c_stretch: cover property (scl_oe_o && adc_start_o);
	c_refused: cover property (pslverr_o);
	c_cal: cover property (cal_start_o);
endmodule : aacg_core_chk
bind aacg_core aacg_core_chk u_chk
(
	.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .scl_oe_o(scl_oe_o), .adc_start_o(adc_start_o),
	.adc_chan_o(adc_chan_o), .adc_done_i(adc_done_i), .cal_start_o(cal_start_o)
);

// [aacg_host_model.sv]
// serial host model pulling the open-drain clock and data wires
`timescale 1ns/100ps
module aacg_host_model
(
	// resolved wire levels
	input wire logic scl_i,
	input wire logic sda_i,
	// high pulls the wire low
	output logic scl_low_o,
	output logic sda_low_o
);
	int stuck;
	initial
	begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
		stuck = 0;
	end
	task automatic start_cond();
		// later wire edges stay 2 ns off the core clock edges, so the synchronisers never race them
		#2;
		sda_low_o = 1'b1;
		#80;
		scl_low_o = 1'b1;
		#24;
	endtask : start_cond
	task automatic stop_cond();
		sda_low_o = 1'b1;
		#80;
		scl_low_o = 1'b0;
		#80;
		sda_low_o = 1'b0;
		#80;
	endtask : stop_cond
	// data moves only well after the clock fell, so no false start or stop is seen
	task automatic bit_io(input logic b, output logic r);
		int n;
		sda_low_o = !b;
		#56;
		scl_low_o = 1'b0;
		for (n = 0; n < 4000 && !scl_i; n++) #8;
		if (!scl_i) stuck++;
		#40;
		r = sda_i;
		#40;
		scl_low_o = 1'b1;
		#24;
	endtask : bit_io
	task automatic byte_io(input logic [7:0] d, input logic ack_bit, output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(ack_bit, ack);
	endtask : byte_io
endmodule : aacg_host_model

// [aacg_core_tb_top.sv]
// self-checking bench for the converter core
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
	$display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (b)); end end
module aacg_core_tb_top
	import aacg_pkg::*;
();
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, adc_start, adc_done, cal_start, cal_done;
	logic scl_oe, sda_oe, alert, host_scl, host_sda, stretched, er, a;
	logic [7:0] paddr, gpio_in, gpio_out, gpio_oe, q;
	logic [31:0] pwdata, prdata, rv;
	logic [2:0] strap, adc_chan;
	logic [11:0] adc_code, code_base;
	logic [7:0] xb [4];
	int failures, comparisons, n_conv, n_cal, dly, cdly;
	wire scl = !(scl_oe || host_scl);
	wire sda = !(sda_oe || host_sda);
	aacg_core uut
	(
		.ref_clk_i(clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
		.addr_strap_i(strap), .adc_start_o(adc_start), .adc_chan_o(adc_chan), .adc_done_i(adc_done),
		.adc_code_i(adc_code), .cal_start_o(cal_start), .cal_done_i(cal_done), .gpio_i(gpio_in),
		.gpio_o(gpio_out), .gpio_oe_o(gpio_oe), .alert_o(alert)
	);
	aacg_host_model u_host (.scl_i(scl), .sda_i(sda), .scl_low_o(host_scl), .sda_low_o(host_sda));
	always #4 clk = ~clk;
	// converter and calibration macro: codes climb by one per sample
	always @(posedge clk)
	begin
		adc_done <= (dly == 1);
		cal_done <= (cdly == 1);
		if (dly == 1)
		begin
			adc_code <= code_base + n_conv[11:0];
			n_conv <= n_conv + 1;
		end
		dly <= adc_start ? 4 : (dly > 0 ? dly - 1 : 0);
		cdly <= cal_start ? 6 : (cdly > 0 ? cdly - 1 : 0);
		n_cal <= n_cal + int'(cal_start);
		if (scl_oe)
			stretched <= 1'b1;
	end
	// ----
	// tasks
	// ----
	task automatic finish_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx[5:0], 2'h0};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++)
		begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (n == 16)
		begin
			failures++;
			finish_test();
		end
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, {24'h0, d});
	endtask : wr
	task automatic rd(input logic [7:0] idx);
		apb(1'b0, idx, 32'h0);
	endtask : rd
	task automatic poll(input logic [7:0] idx, input int b, input logic v);
		int n;
		for (n = 0; n < 64; n++)
		begin
			rd(idx);
			if (rv[b] === v) break;
		end
		if (n == 64)
		begin
			failures++;
			finish_test();
		end
	endtask : poll
	function automatic logic [7:0] crc8(input logic [7:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 7; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc8
	task automatic send(input logic [7:0] b);
		u_host.byte_io(b, 1'b1, q, a);
		`CHK(a, 1'b0)
	endtask : send
	task automatic i2c_wr(input logic crc_on, input logic [7:0] d, input logic [7:0] flip);
		u_host.start_cond();
		send(8'h2E);
		send(REG_OUT);
		if (crc_on) send(crc8(REG_OUT));
		send(d);
		if (crc_on) send(crc8(d) ^ flip);
		u_host.stop_cond();
	endtask : i2c_wr
	// ----
	// scenarios
	// ----
	initial
	begin
		clk = 1'b0;
		resetn = 1'b0;
		{psel, penable, pwrite, adc_done, cal_done, stretched} = '0;
		paddr = 8'h00;
		pwdata = 32'h0;
		strap = 3'h0;
		adc_code = 12'h000;
		code_base = 12'h000;
		gpio_in = 8'h00;
		{failures, comparisons, n_conv, n_cal, dly, cdly} = '0;
		for (int k = 0; k < 8; k++)
		begin
			strap <= k[2:0];
			repeat (6) @(posedge clk);
			resetn <= 1'b1;
			repeat (6) @(posedge clk);
			rd(REG_ADDR);
			`CHK(rv[6:0], 7'h10 + k[6:0])
			if (k < 7) resetn <= 1'b0;
		end
		strap <= 3'h2;
		repeat (8) @(posedge clk);
		rd(REG_ADDR);
		`CHK(rv[6:0], 7'h17)
		rd(REG_THI_L);
		`CHK(rv, 32'hFF)
		rd(REG_THI_H);
		`CHK(rv, 32'h0F)
		rd(8'h0F);
		`CHK({er, rv}, 33'h100000000)
		wr(REG_GENERAL, 8'h01);
		rd(REG_GENERAL);
		`CHK(rv[GEN_CAL], 1'b1)
		poll(REG_GENERAL, GEN_CAL, 1'b0);
		`CHK(n_cal, 1)
		wr(REG_AVG, 8'h02);
		wr(REG_CHAN, 8'h03);
		wr(REG_THI_H, 8'h08);
		n_conv = 0;
		code_base = 12'h800;
		wr(REG_GENERAL, 8'h0C);
		poll(REG_STATUS, STAT_DONE, 1'b1);
		`CHK(rv[STAT_ALERT], 1'b0)
		`CHK(n_conv, 4)
		rd(REG_RES_FIRST + 8'h06);
		`CHK(rv[7:0], 8'h18)
		rd(REG_RES_FIRST + 8'h07);
		`CHK(rv[7:0], 8'h80)
		wr(REG_STATUS, 8'h02);
		rd(REG_STATUS);
		`CHK(rv[STAT_DONE], 1'b0)
		gpio_in <= 8'h5A;
		wr(REG_PIN, 8'hFF);
		wr(REG_DIR, 8'hF0);
		wr(REG_DRIVE, 8'h30);
		wr(REG_OUT, 8'hA0);
		repeat (4) @(posedge clk);
		`CHK(gpio_oe, 8'h70)
		`CHK(gpio_out[7:4] & gpio_oe[7:4], 4'h2)
		rd(REG_IN);
		`CHK(rv[3:0], 4'hA)
		wr(REG_PIN, 8'h00);
		wr(REG_GENERAL, 8'h00);
		repeat (4) @(posedge clk);
		`CHK(gpio_oe, 8'h00)
		i2c_wr(1'b0, 8'h33, 8'h00);
		rd(REG_OUT);
		`CHK(rv[7:0], 8'h33)
		wr(REG_GENERAL, 8'h42);
		i2c_wr(1'b1, 8'h55, 8'h00);
		rd(REG_OUT);
		`CHK(rv[7:0], 8'h55)
		i2c_wr(1'b1, 8'hAA, 8'h01);
		rd(REG_OUT);
		`CHK(rv[7:0], 8'h55)
		rd(REG_STATUS);
		`CHK(rv[STAT_CRC], 1'b1)
		`CHK(alert, 1'b1)
		wr(REG_OUT, 8'h0F);
		rd(REG_OUT);
		`CHK(rv[7:0], 8'h55)
		wr(REG_STATUS, 8'h01);
		wr(REG_OUT, 8'h0F);
		`CHK(alert, 1'b0)
		rd(REG_OUT);
		`CHK(rv[7:0], 8'h0F)
		wr(REG_AVG, 8'h01);
		wr(REG_CHAN, 8'h05);
		wr(REG_GENERAL, 8'h02);
		n_conv = 0;
		code_base = 12'hABC;
		stretched = 1'b0;
		xb = '{8'hAB, crc8(8'hAB), 8'hC8, crc8(8'hC8)};
		u_host.start_cond();
		send(8'h2F);
		for (int i = 0; i < 4; i++)
		begin
			u_host.byte_io(8'hFF, i == 3, q, a);
			`CHK(q, xb[i])
		end
		u_host.stop_cond();
		`CHK(n_conv, 2)
		`CHK(stretched, 1'b1)
		`CHK(adc_chan, 3'h5)
		`CHK(u_host.stuck, 0)
		finish_test();
	end
	initial
	begin
		#800000;
		failures++;
		finish_test();
	end
endmodule : aacg_core_tb_top
